// [hw/pti_top.v]
// dual pcm port front end: mode detect, slot map, config select
// assumes pins asynchronous to core_clk; bit clock far below core_clk
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "pti_defines.vh"
module pti_top #(
    parameter [23:0] SSI_HOLD_CYC = `PTI_SSI_HOLD_CYC
) (
    input wire core_clk,
    input wire srst,
    input wire tdm_bus_clock_in,
    input wire frame_pulse_in_n,
    input wire strobe_a_port_one,
    input wire strobe_b_port_one,
    input wire strobe_a_port_two,
    input wire strobe_b_port_two,
    input wire config_pin_first,
    input wire config_pin_second,
    input wire format_pin,
    input wire law_pin,
    input wire rin,
    input wire sin,
    output reg sout,
    output reg sout_oe,
    output reg rout,
    output reg rout_oe,
    output wire [15:0] a_rin_word,
    output wire a_rin_valid,
    output wire [15:0] b_rin_word,
    output wire b_rin_valid,
    output wire [15:0] a_sin_word,
    output wire a_sin_valid,
    output wire [15:0] b_sin_word,
    output wire b_sin_valid,
    input wire [15:0] a_sout_word,
    input wire [15:0] b_sout_word,
    input wire [15:0] a_rout_word,
    input wire [15:0] b_rout_word,
    output reg [2:0] cfg_onehot,
    output reg frame_start,
    output reg [31:0] code_points,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest
);
wire [12:0] pins_s;
wire bclk_s;
wire fp_n_s;
wire sa1_s;
wire sb1_s;
wire sa2_s;
wire sb2_s;
wire [1:0] cfg_pins_s;
wire fmt_s;
wire law_s;
wire rin_s;
wire sin_s;
reg bclk_d_r;
reg fp_n_d_r;
reg sa1_d_r;
reg fp_hit_r;
reg [1:0] ctrl_r;
reg ack_r;
reg tdm_r;
reg [23:0] lo_cnt_r;
reg phase_r;
reg [7:0] bit_cnt_r;
reg [15:0] dc1_r;
reg [15:0] dc2_r;
reg [2:0] cfg_nxt;
reg [2:0] w1;
reg [2:0] w2;
reg [5:0] win;
wire bclk_rise;
wire bclk_fall;
wire fp_low;
wire tick_smp;
wire tick_lch;
wire smp;
wire lch;
wire ctlr_mode;
wire b_on;
wire [95:0] tx_bus;
wire [95:0] rx_bus;
wire [5:0] rx_vld;
wire [5:0] wide;
wire [5:0] dout;
wire acc;
wire [31:0] status;
// ----------------------------------------
// pin synchronisers
// ----------------------------------------
pti_sync #(
    .W(13)
) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .din({tdm_bus_clock_in, frame_pulse_in_n, strobe_a_port_one,
        strobe_b_port_one, strobe_a_port_two, strobe_b_port_two,
        config_pin_first, config_pin_second, format_pin, law_pin,
        rin, sin, 1'b0}),
    .dout(pins_s)
);
assign bclk_s = pins_s[12];
assign fp_n_s = pins_s[11];
assign sa1_s = pins_s[10];
assign sb1_s = pins_s[9];
assign sa2_s = pins_s[8];
assign sb2_s = pins_s[7];
assign cfg_pins_s = pins_s[6:5];
assign fmt_s = pins_s[4];
assign law_s = pins_s[3];
assign rin_s = pins_s[2];
assign sin_s = pins_s[1];
assign bclk_rise = bclk_s && !bclk_d_r;
assign bclk_fall = !bclk_s && bclk_d_r;
assign fp_low = !fp_n_s;
// ----------------------------------------
// configuration select
// ----------------------------------------
assign ctlr_mode = (cfg_pins_s == `PTI_PIN_CTLR);
always @*
begin
    case (cfg_pins_s)
        `PTI_PIN_EXT: cfg_nxt = `PTI_CFG_EXT;
        `PTI_PIN_B2B: cfg_nxt = `PTI_CFG_B2B;
        `PTI_PIN_NORM: cfg_nxt = `PTI_CFG_NORM;
        default:
        begin
            // both bits set is illegal; back-to-back wins if it happens
            if (ctrl_r[`PTI_CTRL_B2B_BIT])
                cfg_nxt = `PTI_CFG_B2B;
            else if (ctrl_r[`PTI_CTRL_LT_BIT])
                cfg_nxt = `PTI_CFG_EXT;
            else
                cfg_nxt = `PTI_CFG_NORM;
        end
    endcase
end
// ----------------------------------------
// bus convention detect and tdm counters
// ----------------------------------------
// any rising frame pulse means tdm; a long low means ssi
always @(posedge core_clk)
begin
    if (srst)
    begin
        bclk_d_r <= 1'b0;
        fp_n_d_r <= 1'b1;
        sa1_d_r <= 1'b0;
        fp_hit_r <= 1'b0;
        tdm_r <= 1'b0;
        lo_cnt_r <= 24'h000000;
        phase_r <= 1'b0;
        bit_cnt_r <= 8'h00;
        cfg_onehot <= `PTI_CFG_NORM;
        frame_start <= 1'b0;
    end
    else
    begin
        bclk_d_r <= bclk_s;
        fp_n_d_r <= fp_n_s;
        sa1_d_r <= sa1_s;
        // one boundary per pulse, whatever the bus clock phase
        fp_hit_r <= fp_low && (fp_hit_r || bclk_fall);
        cfg_onehot <= cfg_nxt;
        if (!fp_low)
            lo_cnt_r <= 24'h000000;
        else if (lo_cnt_r < SSI_HOLD_CYC)
            lo_cnt_r <= lo_cnt_r + 24'h000001;
        if (fp_low && lo_cnt_r >= SSI_HOLD_CYC)
            tdm_r <= 1'b0;
        else if (fp_n_s && !fp_n_d_r)
            tdm_r <= 1'b1;
        if (bclk_fall && fp_low)
        begin
            phase_r <= 1'b0;
            bit_cnt_r <= 8'h00;
        end
        else if (bclk_fall)
        begin
            phase_r <= !phase_r;
            if (phase_r)
                bit_cnt_r <= bit_cnt_r + 8'h01;
        end
        if (tdm_r)
            frame_start <= bclk_fall && fp_low && !fp_hit_r;
        else
            frame_start <= sa1_s && !sa1_d_r;
    end
end
// two bus-clock falling edges per bit on the tdm bus
assign tick_lch = bclk_fall && !fp_low && !phase_r;
assign tick_smp = bclk_fall && !fp_low && phase_r;
assign smp = tdm_r ? tick_smp : bclk_fall;
assign lch = tdm_r ? tick_lch : bclk_rise;
// ----------------------------------------
// slot windows per port
// ----------------------------------------
// returns {dc, b, a} windows for a port in tdm mode
function [2:0] tdm_win;
    input [1:0] m;
    input [4:0] slot;
    reg [2:0] w;
    begin
        w = 3'h0;
        case (m)
            `PTI_TDM_M1: w = {1'b0, slot == 5'h01, slot == 5'h00};
            `PTI_TDM_M2: w = {1'b0, slot == 5'h03, slot == 5'h02};
            `PTI_TDM_M3: w = {slot < 5'h02, slot == 5'h03, slot == 5'h02};
            `PTI_TDM_M4: w = {1'b0, slot[4:1] == 4'h1, slot[4:1] == 4'h0};
            default: w = 3'h0;
        endcase
        tdm_win = w;
    end
endfunction
// b strobes only steer canceller b in normal configuration
assign b_on = (cfg_onehot == `PTI_CFG_NORM);
always @*
begin
    w1 = tdm_win({sb1_s, sa1_s}, bit_cnt_r[7:3]);
    w2 = tdm_win({sb2_s, sa2_s}, bit_cnt_r[7:3]);
    if (tdm_r)
        win = {w2[2], w1[2], w2[1], w2[0], w1[1], w1[0]};
    else
        win = {2'h0, sb2_s && b_on, sa2_s, sb1_s && b_on, sa1_s};
end
// ----------------------------------------
// lanes: 0 a1, 1 b1, 2 a2, 3 b2, 4 dc1, 5 dc2
// ----------------------------------------
// d/c bytes leave on the opposite port one frame after capture
assign tx_bus = {dc1_r, dc2_r, b_rout_word, a_rout_word,
    b_sout_word, a_sout_word};
genvar gi;
generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_lane
        pti_lane u_lane (
            .core_clk(core_clk),
            .srst(srst),
            .win(win[gi]),
            .smp(smp),
            .lch(lch),
            .din((gi == 0 || gi == 1 || gi == 4) ? rin_s : sin_s),
            .tx_word(tx_bus[gi*16 +: 16]),
            .rx_word(rx_bus[gi*16 +: 16]),
            .rx_valid(rx_vld[gi]),
            .wide(wide[gi]),
            .dout(dout[gi])
        );
    end
endgenerate
assign a_rin_word = rx_bus[15:0];
assign a_rin_valid = rx_vld[0];
assign b_rin_word = rx_bus[31:16];
assign b_rin_valid = rx_vld[1];
assign a_sin_word = rx_bus[47:32];
assign a_sin_valid = rx_vld[2];
assign b_sin_word = rx_bus[63:48];
assign b_sin_valid = rx_vld[3];
// ----------------------------------------
// outputs, pass-through store, code points
// ----------------------------------------
// second slot in non-normal configs carries whatever canceller b gives
always @(posedge core_clk)
begin
    if (srst)
    begin
        sout <= 1'b0;
        sout_oe <= 1'b0;
        rout <= 1'b0;
        rout_oe <= 1'b0;
        dc1_r <= 16'h0000;
        dc2_r <= 16'h0000;
        code_points <= `PTI_SM_CODES;
    end
    else
    begin
        sout <= |(dout & win & 6'h13);
        sout_oe <= |(win & 6'h13);
        rout <= |(dout & win & 6'h2C);
        rout_oe <= |(win & 6'h2C);
        if (rx_vld[4])
            dc1_r <= rx_bus[79:64];
        if (rx_vld[5])
            dc2_r <= rx_bus[95:80];
        if (!fmt_s)
            code_points <= `PTI_SM_CODES;
        else if (!law_s)
            code_points <= `PTI_MU_CODES;
        else
            code_points <= `PTI_A_CODES;
    end
end
// ----------------------------------------
// avalon-mm slave, one wait state
// ----------------------------------------
assign acc = avs_read || avs_write;
assign avs_waitrequest = acc && !ack_r;
assign status = {21'h000000, wide, ctlr_mode, cfg_onehot, tdm_r};
always @(posedge core_clk)
begin
    if (srst)
    begin
        ack_r <= 1'b0;
        ctrl_r <= `PTI_CTRL_RST;
        avs_readdata <= 32'h00000000;
    end
    else
    begin
        ack_r <= acc && !ack_r;
        if (avs_read && !ack_r)
        begin
            if (avs_address == `PTI_CTRL_OFS)
                avs_readdata <= {30'h00000000, ctrl_r};
            else if (avs_address == `PTI_STAT_OFS)
                avs_readdata <= status;
            else
                avs_readdata <= 32'h00000000;
        end
        if (avs_write && ack_r && avs_address == `PTI_CTRL_OFS &&
            avs_byteenable[0])
            ctrl_r <= avs_writedata[1:0];
    end
end
endmodule // pti_top

// [hw/pti_defines.vh]
// constants for the dual pcm port front end
// assumes inclusion by bare name from the pti_top design file
// What this block does
// - config pins: 00 controller, 01 extended delay, 10 back-to-back, 11 normal
// - controller: both bits 0 normal, back-to-back bit alone, long-tail bit alone
// - normal: two independent parallel channels, 64 ms each
// - back-to-back: full duplex single channel, one slot per port
// - extended delay: both cancellers cascaded into one 128 ms canceller
// - port one: reference in, send out; port two: send in, reference out
// - frame pulse seen selects tdm; input held low selects strobed serial
// - tdm enable pins pick slots 0/1, 2/3, 2/3 plus d/c, or linear 0-3
// - non-normal configs may send undefined data in second slot
// - strobed normal: canceller a on a-strobes, b on b-strobes, per port
// - strobes active high, 8 or 16 bit clocks; length sets word type
// - strobed mode frame boundary is rise of port one a-strobe
// - ports may use different strobe lengths independently
// - format pin: 0 sign-magnitude, 1 g.711; law pin: 0 mu, 1 a
// - sign-magnitude codes ff, 80, 00, 7f for the four scale points
// - g.711 mu codes 80, ff, 7f, 00; a-law aa, d5, 55, 2a
// - strobed: sample input on falling edge, launch output on rising
// - tdm mode 3 passes d/c bytes through with one frame latency
`ifndef PTI_DEFINES_VH
`define PTI_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define PTI_CTRL_OFS 4'h0
`define PTI_STAT_OFS 4'h4
`define PTI_CTRL_B2B_BIT 0
`define PTI_CTRL_LT_BIT 1
`define PTI_CTRL_RST 2'h0
`define PTI_ST_TDM_BIT 0
`define PTI_ST_CFG_LSB 1
`define PTI_ST_CTLR_BIT 4
`define PTI_ST_WIDE_LSB 5
// ----------------------------------------
// configuration and modes
// ----------------------------------------
`define PTI_PIN_CTLR 2'h0
`define PTI_PIN_EXT 2'h1
`define PTI_PIN_B2B 2'h2
`define PTI_PIN_NORM 2'h3
`define PTI_CFG_NORM 3'h1
`define PTI_CFG_B2B 3'h2
`define PTI_CFG_EXT 3'h4
`define PTI_TDM_M1 2'h0
`define PTI_TDM_M2 2'h1
`define PTI_TDM_M3 2'h2
`define PTI_TDM_M4 2'h3
// ----------------------------------------
// companded code points
// ----------------------------------------
`define PTI_SM_CODES 32'hFF80007F
`define PTI_MU_CODES 32'h80FF7F00
`define PTI_A_CODES 32'hAAD5552A
// ----------------------------------------
// timing
// ----------------------------------------
`define PTI_CLK_MHZ 100
`define PTI_SSI_HOLD_NS 250000
// 250 us at 100 MHz, sized to the low-time counter
`define PTI_SSI_HOLD_CYC 24'h0061A8
`endif

// [hw/pti_sync.v]
// two-flop synchroniser for a group of pin inputs
// assumes inputs unrelated to core_clk, levels only
`timescale 1ns/100ps
module pti_sync #(
    parameter W = 1
) (
    input wire core_clk,
    input wire srst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
reg [W-1:0] meta_r;
// ----------------------------------------
// two stages, first read only by second
// ----------------------------------------
always @(posedge core_clk)
begin
    if (srst)
    begin
        meta_r <= {W{1'b0}};
        dout <= {W{1'b0}};
    end
    else
    begin
        meta_r <= din;
        dout <= meta_r;
    end
end
endmodule // pti_sync

// [hw/pti_lane.v]
// one serial word lane: window, shift in, shift out, length detect
// assumes sample and launch pulses come from core_clk edge detection
`timescale 1ns/100ps
module pti_lane (
    input wire core_clk,
    input wire srst,
    input wire win,
    input wire smp,
    input wire lch,
    input wire din,
    input wire [15:0] tx_word,
    output reg [15:0] rx_word,
    output reg rx_valid,
    output reg wide,
    output reg dout
);
reg win_d_r;
reg [15:0] tx_sh_r;
reg [15:0] rx_sh_r;
reg [4:0] cnt_r;
wire [15:0] tx_al;
// narrow words are left aligned so the msb always leaves first
assign tx_al = wide ? tx_word : {tx_word[7:0], 8'h00};
// ----------------------------------------
// shifters
// ----------------------------------------
always @(posedge core_clk)
begin
    if (srst)
    begin
        win_d_r <= 1'b0;
        tx_sh_r <= 16'h0000;
        rx_sh_r <= 16'h0000;
        cnt_r <= 5'h00;
        rx_word <= 16'h0000;
        rx_valid <= 1'b0;
        wide <= 1'b0;
        dout <= 1'b0;
    end
    else
    begin
        win_d_r <= win;
        rx_valid <= 1'b0;
        if (win && !win_d_r)
        begin
            cnt_r <= 5'h00;
            rx_sh_r <= 16'h0000;
            if (lch)
            begin
                dout <= tx_al[15];
                tx_sh_r <= {tx_al[14:0], 1'b0};
            end
            else
                tx_sh_r <= tx_al;
        end
        else if (win)
        begin
            if (lch)
            begin
                dout <= tx_sh_r[15];
                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
            end
            if (smp)
            begin
                rx_sh_r <= {rx_sh_r[14:0], din};
                cnt_r <= cnt_r + 5'h01;
            end
        end
        // width follows the strobe length of the last frame
        if (!win && win_d_r)
        begin
            rx_valid <= 1'b1;
            wide <= (cnt_r > 5'h08);
            rx_word <= (cnt_r > 5'h08) ? rx_sh_r : {8'h00, rx_sh_r[7:0]};
        end
    end
end
endmodule // pti_lane

// [tb/pti_top_assertions.sv]
// checker for the pcm port front end, sees only top ports
// assumes one core_clk domain and srst synchronous active high
`timescale 1ns/100ps
module pti_top_chk (
    input wire core_clk,
    input wire srst,
    input wire config_pin_first,
    input wire config_pin_second,
    input wire format_pin,
    input wire law_pin,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [31:0] avs_readdata,
    input wire [2:0] cfg_onehot,
    input wire [31:0] code_points,
    input wire frame_start,
    input wire a_rin_valid
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // pins cross two sync flops, five stable cycles is ample
    a_pins_normal: assert property (
        (config_pin_first && config_pin_second)[*5] |-> cfg_onehot == 3'h1)
        else $error("normal pins not decoded");
    a_pins_duplex: assert property (
        (config_pin_first && !config_pin_second)[*5] |-> cfg_onehot == 3'h2)
        else $error("back to back pins not decoded");
    a_pins_cascade: assert property (
        (!config_pin_first && config_pin_second)[*5] |-> cfg_onehot == 3'h4)
        else $error("extended pins not decoded");
    a_cfg_single: assert property ($onehot(cfg_onehot))
        else $error("config not one hot");
    a_code_signmag: assert property (
        (!format_pin)[*5] |-> code_points == 32'hFF80007F)
        else $error("sign magnitude codes wrong");
    a_code_mulaw: assert property (
        (format_pin && !law_pin)[*5] |-> code_points == 32'h80FF7F00)
        else $error("mu law codes wrong");
    a_code_alaw: assert property (
        (format_pin && law_pin)[*5] |-> code_points == 32'hAAD5552A)
        else $error("a law codes wrong");
    a_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait state");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address != 4'h0
        && avs_address != 4'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    c_frame: cover property (frame_start);
    c_rx_word: cover property (a_rin_valid);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule // pti_top_chk

bind pti_top pti_top_chk chk_u (.core_clk(core_clk), .srst(srst),
    .config_pin_first(config_pin_first),
    .config_pin_second(config_pin_second), .format_pin(format_pin),
    .law_pin(law_pin), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .cfg_onehot(cfg_onehot),
    .code_points(code_points), .frame_start(frame_start),
    .a_rin_valid(a_rin_valid));

// [tb/pti_far_model.sv]
// strobed serial bus master model, one window per go request
// assumes bit clock of 80 ns, stopped outside windows
`timescale 1ns/100ps
module pti_far_model (
    input wire go,
    input wire [1:0] sel,
    input wire [4:0] nbits,
    input wire [15:0] word,
    input wire dev_out,
    output reg bclk,
    output reg [3:0] strobes,
    output reg dq,
    output reg busy,
    output reg [15:0] got
);
    integer i;
    initial
    begin
        bclk = 1'b0;
        strobes = 4'h0;
        dq = 1'b0;
        busy = 1'b0;
        got = 16'h0000;
    end
    // ----------------------------------------
    // window: strobe high for exactly nbits clocks
    // ----------------------------------------
    always @(posedge go)
    begin
        busy = 1'b1;
        strobes[sel] = 1'b1;
        #40;
        for (i = nbits - 1; i >= 0; i = i - 1)
        begin
            bclk = 1'b1;
            dq = word[i];
            #40;
            bclk = 1'b0;
            #35;
            // late in the low half so the synced launch has landed
            got = {got[14:0], dev_out};
            #5;
        end
        strobes[sel] = 1'b0;
        #40;
        // released line shows the inverse, not a stale value
        dq = ~dq;
        busy = 1'b0;
    end
endmodule // pti_far_model

// [tb/pti_top_tb.sv]
// self-checking bench for the dual pcm port front end
// assumes far side model drives strobes, bit clock and serial data
`timescale 1ns/100ps
module pti_top_tb;
    reg core_clk = 0, srst = 1, fp_n = 0, cfg1 = 0, cfg2 = 0;
    reg fmt = 0, law = 0, go = 0, avs_read = 0, avs_write = 0;
    reg [3:0] avs_address = 0, avs_byteenable = 0;
    reg [31:0] avs_writedata = 0, q;
    reg [15:0] a_so = 0, b_so = 0, a_ro = 0, b_ro = 0, rxw, txw, msk;
    reg [1:0] sel = 0;
    reg [4:0] nbits = 8;
    reg [15:0] word = 0;
    wire bclk, dq, busy, sout, rout, a_rv, avs_waitrequest, frame_start;
    wire [3:0] stb;
    wire [15:0] got, a_ri, b_ri, a_si, b_si;
    wire [2:0] cfg_onehot;
    wire [31:0] code_points, avs_readdata;
    integer bad_count = 0, num_checks = 0, fs_cnt = 0, f, k;
    reg [15:0] rx_tab [0:3];
    reg [4:0] nb_tab [0:3];

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (frame_start === 1'b1) fs_cnt++;

    pti_far_model far_u (.go(go), .sel(sel), .nbits(nbits), .word(word),
        .dev_out(sel[1] ? rout : sout), .bclk(bclk), .strobes(stb),
        .dq(dq), .busy(busy), .got(got));

    pti_top #(.SSI_HOLD_CYC(24'd200)) dut_u (.core_clk(core_clk),
        .srst(srst), .tdm_bus_clock_in(bclk), .frame_pulse_in_n(fp_n),
        .strobe_a_port_one(stb[0]), .strobe_b_port_one(stb[1]),
        .strobe_a_port_two(stb[2]), .strobe_b_port_two(stb[3]),
        .config_pin_first(cfg1), .config_pin_second(cfg2),
        .format_pin(fmt), .law_pin(law), .rin(dq), .sin(dq), .sout(sout),
        .sout_oe(), .rout(rout), .rout_oe(), .a_rin_word(a_ri),
        .a_rin_valid(a_rv), .b_rin_word(b_ri), .b_rin_valid(),
        .a_sin_word(a_si), .a_sin_valid(), .b_sin_word(b_si),
        .b_sin_valid(), .a_sout_word(a_so), .b_sout_word(b_so),
        .a_rout_word(a_ro), .b_rout_word(b_ro), .cfg_onehot(cfg_onehot),
        .frame_start(frame_start), .code_points(code_points),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task finish_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                seen, exp);
        end
    end
    endtask

    task bus(input wr, input [3:0] a, input [31:0] d, input [3:0] be);
        integer n;
    begin
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            finish_test;
        end
    end
    endtask

    task wait_busy(input v);
        integer n;
    begin
        for (n = 0; busy !== v && n < 400; n++) @(posedge core_clk);
        if (busy !== v)
        begin
            bad_count++;
            finish_test;
        end
    end
    endtask

    task xfer(input [1:0] s);
    begin
        @(posedge core_clk);
        sel <= s;
        nbits <= nb_tab[s];
        word <= rx_tab[s];
        go <= 1'b1;
        wait_busy(1'b1);
        go <= 1'b0;
        wait_busy(1'b0);
        repeat (20) @(posedge core_clk);
    end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rx_tab[0] = 16'h00C3; rx_tab[1] = 16'h0096;
        rx_tab[2] = 16'h1A68; rx_tab[3] = 16'h002D;
        nb_tab[0] = 8; nb_tab[1] = 8; nb_tab[2] = 16; nb_tab[3] = 8;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        bus(0, 4'h0, 0, 4'hF);
        chk(q, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            bus(1, 4'h0, k, 4'hF);
            repeat (6) @(posedge core_clk);
            chk(cfg_onehot, k == 0 ? 3'h1 : 3'(2 * k));
            bus(0, 4'h4, 0, 4'hF);
            chk(q[4:1], k == 0 ? 4'h9 : k == 1 ? 4'hA : 4'hC);
        end
        bus(1, 4'h0, 32'h1, 4'hE);
        bus(0, 4'h0, 0, 4'hF);
        chk(q, 32'h2);
        bus(0, 4'h8, 0, 4'hF);
        chk(q, 32'h0);
        for (k = 1; k < 4; k++)
        begin
            {cfg1, cfg2} <= 2'(k);
            repeat (6) @(posedge core_clk);
            chk(cfg_onehot, k == 1 ? 3'h4 : k == 2 ? 3'h2 : 3'h1);
        end
        for (k = 0; k < 4; k++)
        begin
            {fmt, law} <= 2'(k);
            repeat (6) @(posedge core_clk);
            chk(code_points, k < 2 ? 32'hFF80007F : k == 2 ?
                32'h80FF7F00 : 32'hAAD5552A);
        end
        repeat (250) @(posedge core_clk);
        for (f = 0; f < 2; f++)
        begin
            a_so <= 16'h00A5 + f; b_so <= 16'h003C + f;
            a_ro <= 16'hF271 + f; b_ro <= 16'h004E + f;
            for (k = 0; k < 4; k++)
            begin
                xfer(2'(k));
                msk = nb_tab[k] == 8 ? 16'h00FF : 16'hFFFF;
                rxw = k == 0 ? a_ri : k == 1 ? b_ri : k == 2 ? a_si : b_si;
                txw = k == 0 ? a_so : k == 1 ? b_so : k == 2 ? a_ro : b_ro;
                chk(rxw & msk, rx_tab[k]);
                if (f == 1)
                    chk(got & msk, txw & msk);
            end
        end
        chk(fs_cnt, 2);
        bus(0, 4'h4, 0, 4'hF);
        chk(q[0], 1'b0);
        chk(q[8:5], 4'h4);
        // a rising frame pulse selects tdm, a long low returns to ssi
        fp_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        bus(0, 4'h4, 0, 4'hF);
        chk(q[0], 1'b1);
        fp_n <= 1'b0;
        repeat (220) @(posedge core_clk);
        bus(0, 4'h4, 0, 4'hF);
        chk(q[0], 1'b0);
        finish_test;
    end
endmodule // pti_top_tb
